// [design/display_memory_window_mapper.sv]
// display memory window mapper: offset windows and write-mode extensions
//
// Function
// - offset zero used unless second window selected
// - offset one only when dual and bit15 high
// - granularity bit makes offset a 16K page
// - aperture bit16 zero, bit15 only 64K single
// - 4K mode adds offset to aperture page
// - 16K mode adds offset shifted left two
// - second window adds another 32K aperture
// - enhanced plus extended shifts address by four
// - enhanced uses color extensions, mask per pixel
// - latch enable makes data latches eight bytes
// - extended writes eight bytes, modes 4, 5
// - extended writes widen set/reset and mask
// - enhanced needs extended; disabling clears upper bits
// - by-eight addressing shifts address by three
`timescale 1ns/100ps
module display_memory_window_mapper (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] regIndex,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic hostReq,
	input wire logic [mapper_pkg::HOST_ADDR_W-1:0] hostAddr,
	input wire logic [1:0] memMapSelect,
	input wire logic [7:0] planeWriteMaskIn,
	input wire logic [2:0] writeModeReq,
	output logic dispAddrValid,
	output logic [mapper_pkg::DISP_ADDR_W-1:0] summedDisplayAddress,
	output logic [mapper_pkg::PIXEL_ADDR_W-1:0] pixelByteAddress,
	output logic windowOneSelected,
	output mapper_pkg::pix_mode_t pixelMode,
	output logic latchEightBytes,
	output logic [4:0] bytesPerTransfer,
	output logic [2:0] writeMode,
	output logic [7:0] setResetValue,
	output logic [7:0] setResetEnable,
	output logic [7:0] planeWriteMask,
	output logic colorExtEnabled,
	output logic [7:0] foregroundExt,
	output logic [7:0] backgroundExt
);
	import mapper_pkg::*;

	// ==========================================================
	// register file
	logic [7:0] offsetZero_ff;
	logic [7:0] offsetOne_ff;
	logic [7:0] modeExt_ff;
	logic [7:0] setResetValue_ff;
	logic [7:0] setResetEnable_ff;
	logic [7:0] fgExt_ff;
	logic [7:0] bgExt_ff;
	logic [7:0] regRdData_ff;
	logic modeExtWrite;
	logic extWritesFalling;

	assign modeExtWrite = regWrite && (regIndex == IDX_GRAPHICS_MODE_EXT);
	assign extWritesFalling = modeExtWrite && modeExt_ff[BIT_EXT_WRITES] && !regWrData[BIT_EXT_WRITES];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			offsetZero_ff <= RST_WINDOW_OFFSET;
			offsetOne_ff <= RST_WINDOW_OFFSET;
			modeExt_ff <= RST_GRAPHICS_MODE_EXT;
			fgExt_ff <= RST_COLOR_EXT;
			bgExt_ff <= RST_COLOR_EXT;
		end else if (regWrite) begin
			if (regIndex == IDX_WINDOW_OFFSET_ZERO) begin
				offsetZero_ff <= regWrData;
			end else if (regIndex == IDX_WINDOW_OFFSET_ONE) begin
				offsetOne_ff <= regWrData;
			end else if (regIndex == IDX_GRAPHICS_MODE_EXT) begin
				modeExt_ff <= regWrData & GRAPHICS_MODE_EXT_MASK;
			end else if (regIndex == IDX_FOREGROUND_EXT) begin
				fgExt_ff <= regWrData;
			end else if (regIndex == IDX_BACKGROUND_EXT) begin
				bgExt_ff <= regWrData;
			end
		end
	end

	// set/reset storage keeps all eight bits; turning extended writes off
	// wipes the upper nibble so stale bits cannot leak into a later mode
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			setResetValue_ff <= RST_SET_RESET;
			setResetEnable_ff <= RST_SET_RESET;
		end else if (extWritesFalling) begin
			setResetValue_ff <= {4'h0, setResetValue_ff[3:0]};
			setResetEnable_ff <= {4'h0, setResetEnable_ff[3:0]};
		end else if (regWrite && (regIndex == IDX_SET_RESET_VALUE)) begin
			setResetValue_ff <= regWrData;
		end else if (regWrite && (regIndex == IDX_SET_RESET_ENABLE)) begin
			setResetEnable_ff <= regWrData;
		end
	end

	// unmapped indexes and reserved bits read as zero
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regRdData_ff <= RST_READ_DATA;
		end else if (regRead) begin
			if (regIndex == IDX_WINDOW_OFFSET_ZERO) begin
				regRdData_ff <= offsetZero_ff;
			end else if (regIndex == IDX_WINDOW_OFFSET_ONE) begin
				regRdData_ff <= offsetOne_ff;
			end else if (regIndex == IDX_GRAPHICS_MODE_EXT) begin
				regRdData_ff <= modeExt_ff;
			end else if (regIndex == IDX_SET_RESET_VALUE) begin
				regRdData_ff <= setResetValue_ff;
			end else if (regIndex == IDX_SET_RESET_ENABLE) begin
				regRdData_ff <= setResetEnable_ff;
			end else if (regIndex == IDX_FOREGROUND_EXT) begin
				regRdData_ff <= fgExt_ff;
			end else if (regIndex == IDX_BACKGROUND_EXT) begin
				regRdData_ff <= bgExt_ff;
			end else begin
				regRdData_ff <= RST_READ_DATA;
			end
		end
	end

	// ==========================================================
	// mode decode
	logic dualWindow;
	logic granularity16k;
	logic extWrites;
	logic enhancedWrites;
	logic memMap64k;

	assign dualWindow = modeExt_ff[BIT_DUAL_WINDOW];
	assign granularity16k = modeExt_ff[BIT_GRANULARITY];
	assign extWrites = modeExt_ff[BIT_EXT_WRITES];
	assign enhancedWrites = modeExt_ff[BIT_ENHANCED] && extWrites;
	assign memMap64k = (memMapSelect == 2'b00) || (memMapSelect == 2'b01);

	// ==========================================================
	// window address
	addr_calc_if calc ();
	logic useWindowOne;
	logic xaBit15;
	logic [DISP_ADDR_W-1:0] nxtSummedAddr;
	logic [PIXEL_ADDR_W-1:0] nxtPixelAddr;
	pix_mode_t nxtPixelMode;

	// second window answers the upper 32K half of the aperture
	assign useWindowOne = dualWindow && hostAddr[HOST_WINDOW_BIT];
	assign calc.offset = useWindowOne ? offsetOne_ff : offsetZero_ff;
	assign calc.granularity16k = granularity16k;
	assign xaBit15 = (memMap64k && !dualWindow) ? hostAddr[HOST_WINDOW_BIT] : 1'b0;
	assign calc.xaPage = {1'b0, xaBit15, hostAddr[14:PAGE_LSB]};

	window_offset_adder adder (
		.calc(calc)
	);

	assign nxtSummedAddr = {calc.summedPage, hostAddr[PAGE_LSB-1:0]};

	// with both set by software error, by-sixteen wins
	always_comb begin
		if (enhancedWrites) begin
			nxtPixelMode = BY_SIXTEEN;
		end else if (modeExt_ff[BIT_BY_EIGHT]) begin
			nxtPixelMode = BY_EIGHT;
		end else begin
			nxtPixelMode = PACKED;
		end
	end

	always_comb begin
		case (nxtPixelMode)
			BY_SIXTEEN: nxtPixelAddr = {nxtSummedAddr, 4'h0};
			BY_EIGHT: nxtPixelAddr = {1'b0, nxtSummedAddr, 3'h0};
			default: nxtPixelAddr = {4'h0, nxtSummedAddr};
		endcase
	end

	logic dispAddrValid_ff;
	logic [DISP_ADDR_W-1:0] summedAddr_ff;
	logic [PIXEL_ADDR_W-1:0] pixelAddr_ff;
	logic windowOne_ff;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dispAddrValid_ff <= 1'b0;
		end else begin
			dispAddrValid_ff <= hostReq;
		end
	end

	// address holds between accesses
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			summedAddr_ff <= '0;
			pixelAddr_ff <= '0;
			windowOne_ff <= 1'b0;
		end else if (hostReq) begin
			summedAddr_ff <= nxtSummedAddr;
			pixelAddr_ff <= nxtPixelAddr;
			windowOne_ff <= useWindowOne;
		end
	end

	// ==========================================================
	// write-mode extensions
	pix_mode_t pixelMode_ff;
	logic latchEight_ff;
	logic [4:0] bytesPer_ff;
	logic [2:0] writeMode_ff;
	logic [7:0] srValueOut_ff;
	logic [7:0] srEnableOut_ff;
	logic [7:0] planeMask_ff;
	logic colorExt_ff;
	logic [7:0] fgOut_ff;
	logic [7:0] bgOut_ff;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pixelMode_ff <= PACKED;
			latchEight_ff <= 1'b0;
			bytesPer_ff <= BYTES_NORMAL;
			writeMode_ff <= 3'h0;
			colorExt_ff <= 1'b0;
		end else begin
			pixelMode_ff <= nxtPixelMode;
			latchEight_ff <= modeExt_ff[BIT_EIGHT_BYTE_LATCH];
			bytesPer_ff <= enhancedWrites ? BYTES_ENHANCED :
				(extWrites ? BYTES_EXTENDED : BYTES_NORMAL);
			// modes 4 and 5 need extended writes
			writeMode_ff <= extWrites ? writeModeReq : {1'b0, writeModeReq[1:0]};
			colorExt_ff <= enhancedWrites;
		end
	end

	// in 4-bit mode the upper nibble is hidden; for set/reset it is also lost on entry
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			srValueOut_ff <= RST_SET_RESET;
			srEnableOut_ff <= RST_SET_RESET;
			planeMask_ff <= 8'h00;
			fgOut_ff <= RST_COLOR_EXT;
			bgOut_ff <= RST_COLOR_EXT;
		end else begin
			srValueOut_ff <= extWrites ? setResetValue_ff : {4'h0, setResetValue_ff[3:0]};
			srEnableOut_ff <= extWrites ? setResetEnable_ff : {4'h0, setResetEnable_ff[3:0]};
			planeMask_ff <= extWrites ? planeWriteMaskIn : {4'h0, planeWriteMaskIn[3:0]};
			fgOut_ff <= enhancedWrites ? fgExt_ff : RST_COLOR_EXT;
			bgOut_ff <= enhancedWrites ? bgExt_ff : RST_COLOR_EXT;
		end
	end

	assign regRdData = regRdData_ff;
	assign dispAddrValid = dispAddrValid_ff;
	assign summedDisplayAddress = summedAddr_ff;
	assign pixelByteAddress = pixelAddr_ff;
	assign windowOneSelected = windowOne_ff;
	assign pixelMode = pixelMode_ff;
	assign latchEightBytes = latchEight_ff;
	assign bytesPerTransfer = bytesPer_ff;
	assign writeMode = writeMode_ff;
	assign setResetValue = srValueOut_ff;
	assign setResetEnable = srEnableOut_ff;
	assign planeWriteMask = planeMask_ff;
	assign colorExtEnabled = colorExt_ff;
	assign foregroundExt = fgOut_ff;
	assign backgroundExt = bgOut_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_window_zero_pick: assert property (
		hostReq && !(dualWindow && hostAddr[15]) |=> dispAddrValid && !windowOneSelected)
		else $error("offset zero not chosen");
	a_window_one_pick: assert property (
		hostReq && dualWindow && hostAddr[15] |=> dispAddrValid && windowOneSelected)
		else $error("offset one not chosen");
	a_fourk_top_zero: assert property (
		hostReq && !granularity16k |=> summedDisplayAddress[21:20] == 2'b00)
		else $error("4K sum reached above bit 19");
	a_sixteenk_low_pages: assert property (
		hostReq && granularity16k |=> summedDisplayAddress[13:12] == $past(hostAddr[13:12]))
		else $error("16K offset touched bits 13:12");
	a_low_bits_pass: assert property (
		dispAddrValid |-> summedDisplayAddress[11:0] == $past(hostAddr[11:0]))
		else $error("page offset bits altered");
	// register lands on the next edge, the latch output one edge later; that
	// output is sampled at the third edge, so a write right behind that clears it fails
	a_latch_width: assert property (
		modeExtWrite && regWrData[BIT_EIGHT_BYTE_LATCH] |-> ##3 latchEightBytes)
		else $error("eight byte latches not enabled");
	a_ext_clear_upper: assert property (
		extWritesFalling |=> setResetValue_ff[7:4] == 4'h0 && setResetEnable_ff[7:4] == 4'h0)
		else $error("set/reset upper nibble survived");
	a_enhanced_needs_ext: assert property (
		colorExtEnabled |-> $past(extWrites))
		else $error("enhanced writes without extended");
	a_by_sixteen_shift: assert property (
		dispAddrValid && $past(enhancedWrites) |-> pixelByteAddress[3:0] == 4'h0)
		else $error("by-sixteen address not shifted");
	a_by_eight_shift: assert property (
		hostReq && nxtPixelMode == BY_EIGHT |=> pixelByteAddress[2:0] == 3'h0)
		else $error("by-eight address not shifted");
	a_narrow_mask: assert property (
		!extWrites |=> planeWriteMask[7:4] == 4'h0 && writeMode[2] == 1'b0)
		else $error("4-bit mode exposed wide fields");
endmodule // display_memory_window_mapper

// [design/mapper_pkg.sv]
// constants shared by the display memory window mapper
package mapper_pkg;
	// register indexes on the graphics controller index/data port
	localparam logic [7:0] IDX_SET_RESET_VALUE = 8'h00;
	localparam logic [7:0] IDX_SET_RESET_ENABLE = 8'h01;
	localparam logic [7:0] IDX_WINDOW_OFFSET_ZERO = 8'h09;
	localparam logic [7:0] IDX_WINDOW_OFFSET_ONE = 8'h0a;
	localparam logic [7:0] IDX_GRAPHICS_MODE_EXT = 8'h0b;
	localparam logic [7:0] IDX_BACKGROUND_EXT = 8'h10;
	localparam logic [7:0] IDX_FOREGROUND_EXT = 8'h11;
	// values after reset
	localparam logic [7:0] RST_WINDOW_OFFSET = 8'h00;
	localparam logic [7:0] RST_GRAPHICS_MODE_EXT = 8'h00;
	localparam logic [7:0] RST_SET_RESET = 8'h00;
	localparam logic [7:0] RST_COLOR_EXT = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	// graphics_mode_extensions field positions
	localparam int BIT_DUAL_WINDOW = 0;
	localparam int BIT_BY_EIGHT = 1;
	localparam int BIT_EXT_WRITES = 2;
	localparam int BIT_EIGHT_BYTE_LATCH = 3;
	localparam int BIT_ENHANCED = 4;
	localparam int BIT_GRANULARITY = 5;
	localparam logic [7:0] GRAPHICS_MODE_EXT_MASK = 8'h3f;
	// widths
	localparam int HOST_ADDR_W = 17;
	localparam int DISP_ADDR_W = 22;
	localparam int PIXEL_ADDR_W = 26;
	localparam int PAGE_LSB = 12;
	localparam int HOST_WINDOW_BIT = 15;
	// bytes written per cpu byte, latch widths
	localparam logic [4:0] BYTES_NORMAL = 5'h04;
	localparam logic [4:0] BYTES_EXTENDED = 5'h08;
	localparam logic [4:0] BYTES_ENHANCED = 5'h10;
	typedef enum logic [1:0] {PACKED, BY_EIGHT, BY_SIXTEEN} pix_mode_t;
endpackage

// [design/addr_calc_if.sv]
// carrier between the mapper and its window offset adder
`timescale 1ns/100ps
interface addr_calc_if;
	logic [7:0] offset;
	logic granularity16k;
	logic [4:0] xaPage;
	logic [9:0] summedPage;
	modport requester (output offset, output granularity16k, output xaPage, input summedPage);
	modport adder (input offset, input granularity16k, input xaPage, output summedPage);
endinterface

// [design/window_offset_adder.sv]
// sums a window offset with the aperture page at 4K or 16K granularity
`timescale 1ns/100ps
module window_offset_adder (
	addr_calc_if.adder calc
);
	import mapper_pkg::*;
	logic [7:0] sum4k;

	always_comb begin
		// carry out of the top bit is dropped on purpose
		sum4k = calc.offset + 8'(calc.xaPage);
		if (calc.granularity16k) begin
			// offset bit 7 would land in page bit 9 and is ignored
			calc.summedPage = 10'({calc.offset[6:0], 2'b00}) + 10'(calc.xaPage);
		end else begin
			calc.summedPage = {2'b00, sum4k};
		end
	end
endmodule // window_offset_adder

// [verif/host_bus_model.sv]
// host processor model driving the display memory aperture
`timescale 1ns/100ps
module host_bus_model (
	input wire logic sys_clk,
	output logic hostReq,
	output logic [mapper_pkg::HOST_ADDR_W-1:0] hostAddr
);
	import mapper_pkg::*;
	initial begin
		hostReq = 1'b0;
		hostAddr = '0;
	end
	// one byte cycle; the released address shows its inverse so a stale
	// value can never pass for the one that was taken
	task automatic access(input logic [HOST_ADDR_W-1:0] addr);
		@(posedge sys_clk);
		#1;
		hostReq = 1'b1;
		hostAddr = addr;
		@(posedge sys_clk);
		#1;
		hostReq = 1'b0;
		hostAddr = ~addr;
	endtask
endmodule // host_bus_model

// [verif/test_display_memory_window_mapper.sv]
// self-checking bench for the display memory window mapper
`timescale 1ns/100ps
module test_display_memory_window_mapper;
	import mapper_pkg::*;
	logic sys_clk, reset, regWrite, regRead, hostReq, dispAddrValid, windowOneSelected;
	logic latchEightBytes, colorExtEnabled;
	logic [7:0] regIndex, regWrData, regRdData, planeWriteMaskIn;
	logic [7:0] setResetValue, setResetEnable, planeWriteMask, foregroundExt, backgroundExt;
	logic [HOST_ADDR_W-1:0] hostAddr;
	logic [1:0] memMapSelect;
	logic [2:0] writeModeReq, writeMode;
	logic [DISP_ADDR_W-1:0] summedDisplayAddress;
	logic [PIXEL_ADDR_W-1:0] pixelByteAddress;
	logic [4:0] bytesPerTransfer;
	pix_mode_t pixelMode;
	int num_errors = 0;
	int num_checks = 0;

	display_memory_window_mapper u_dut (.sys_clk(sys_clk), .reset(reset),
		.regIndex(regIndex), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .hostReq(hostReq), .hostAddr(hostAddr),
		.memMapSelect(memMapSelect), .planeWriteMaskIn(planeWriteMaskIn),
		.writeModeReq(writeModeReq), .dispAddrValid(dispAddrValid),
		.summedDisplayAddress(summedDisplayAddress), .pixelByteAddress(pixelByteAddress),
		.windowOneSelected(windowOneSelected), .pixelMode(pixelMode),
		.latchEightBytes(latchEightBytes), .bytesPerTransfer(bytesPerTransfer),
		.writeMode(writeMode), .setResetValue(setResetValue),
		.setResetEnable(setResetEnable), .planeWriteMask(planeWriteMask),
		.colorExtEnabled(colorExtEnabled), .foregroundExt(foregroundExt),
		.backgroundExt(backgroundExt));
	host_bus_model u_host (.sys_clk(sys_clk), .hostReq(hostReq), .hostAddr(hostAddr));

	// ==========================================
	// clock, checks and closing
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		print_verdict();
	end

	// ==========================================
	// register port and aperture tasks
	// write returns once derived outputs have had their extra edge
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		@(posedge sys_clk);
		#1;
		regIndex = idx;
		regWrData = data;
		regWrite = 1'b1;
		@(posedge sys_clk);
		#1;
		regWrite = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		@(posedge sys_clk);
		#1;
		regIndex = idx;
		regRead = 1'b1;
		@(posedge sys_clk);
		#1;
		regRead = 1'b0;
		chk(regRdData, exp);
	endtask
	task automatic acc(input logic [16:0] a, input logic [21:0] s, input logic w, input int sh);
		u_host.access(a);
		chk(dispAddrValid, 1'b1);
		chk(summedDisplayAddress, s);
		chk(windowOneSelected, w);
		chk(pixelByteAddress, {4'h0, s} << sh);
		@(posedge sys_clk);
		#1;
		chk(dispAddrValid, 1'b0);
	endtask

	// ==========================================
	// tests
	initial begin
		reset = 1'b1;
		{regWrite, regRead} = 2'b00;
		regIndex = 8'h00;
		regWrData = 8'h00;
		memMapSelect = 2'b00;
		planeWriteMaskIn = 8'ha5;
		writeModeReq = 3'b101;
		repeat (10) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		rd(IDX_WINDOW_OFFSET_ZERO, RST_WINDOW_OFFSET);
		rd(IDX_WINDOW_OFFSET_ONE, RST_WINDOW_OFFSET);
		rd(8'h05, RST_READ_DATA);
		chk(bytesPerTransfer, BYTES_NORMAL);
		wr(IDX_GRAPHICS_MODE_EXT, 8'hc0);
		rd(IDX_GRAPHICS_MODE_EXT, 8'h00);
		$display("test registers done");
		wr(IDX_WINDOW_OFFSET_ZERO, 8'h10);
		wr(IDX_WINDOW_OFFSET_ONE, 8'h20);
		acc(17'h0_9123, 22'h01_9123, 1'b0, 0);
		acc(17'h1_8123, 22'h01_8123, 1'b0, 0);
		memMapSelect = 2'b10;
		acc(17'h0_9123, 22'h01_1123, 1'b0, 0);
		memMapSelect = 2'b01;
		wr(IDX_GRAPHICS_MODE_EXT, 8'h01); // no linear addressing here
		acc(17'h0_8123, 22'h02_0123, 1'b1, 0);
		acc(17'h0_4123, 22'h01_4123, 1'b0, 0);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h00);
		wr(IDX_WINDOW_OFFSET_ZERO, 8'hff);
		acc(17'h0_f000, 22'h00_e000, 1'b0, 0);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h21);
		acc(17'h0_7123, 22'h20_3123, 1'b0, 0);
		acc(17'h0_f123, 22'h08_7123, 1'b1, 0);
		$display("test windows done");
		wr(IDX_GRAPHICS_MODE_EXT, 8'h02); // by-eight without enhanced
		chk(pixelMode, BY_EIGHT);
		acc(17'h0_0001, 22'h0f_f001, 1'b0, 3);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h14);
		chk(bytesPerTransfer, BYTES_ENHANCED);
		chk(colorExtEnabled, 1'b1);
		acc(17'h0_0001, 22'h0f_f001, 1'b0, 4);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h10);
		chk(colorExtEnabled, 1'b0);
		chk(bytesPerTransfer, BYTES_NORMAL);
		chk(pixelMode, PACKED);
		rd(IDX_GRAPHICS_MODE_EXT, 8'h10);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h0c);
		chk(latchEightBytes, 1'b1);
		chk(bytesPerTransfer, BYTES_EXTENDED);
		$display("test modes done");
		wr(IDX_SET_RESET_VALUE, 8'hf3);
		wr(IDX_SET_RESET_ENABLE, 8'hc9);
		wr(IDX_FOREGROUND_EXT, 8'h5a);
		wr(IDX_BACKGROUND_EXT, 8'hc3);
		chk(foregroundExt, 8'h00);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h14);
		chk({setResetValue, setResetEnable, planeWriteMask}, 24'hf3_c9a5);
		chk({foregroundExt, backgroundExt}, 16'h5ac3);
		chk(writeMode, 3'b101);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h00);
		chk({setResetValue, setResetEnable, planeWriteMask}, 24'h03_0905);
		chk(writeMode, 3'b001);
		wr(IDX_GRAPHICS_MODE_EXT, 8'h04);
		chk({setResetValue, setResetEnable, planeWriteMask}, 24'h03_09a5);
		$display("test extended writes done");
		print_verdict();
	end
endmodule // test_display_memory_window_mapper
